// [hdl/fcs_fifo.sv]
// dual-port fifo core with configurable timing, flags, offsets and retransmit
`timescale 1ns/100ps
`default_nettype none
module fcs_fifo
    import fcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write port pins
    input wire logic write_clk,
    input wire logic write_enable_n,
    input wire logic [DATA_W-1:0] write_data,
    // read port pins
    input wire logic read_clk,
    input wire logic read_enable_n,
    input wire logic read_chip_select_n,
    input wire logic output_enable_n,
    output logic [DATA_W-1:0] read_data,
    output logic read_data_oe,
    // resets and configuration pins
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic read_port_async_select,
    input wire logic write_port_async_select,
    input wire logic default_offset_select_0,
    input wire logic default_offset_select_1,
    input wire logic flag_timing_select,
    input wire logic first_word_fallthrough_select,
    input wire logic offset_load_enable_n,
    // serial offset programming
    input wire logic serial_clk,
    input wire logic serial_enable_n,
    // mark and retransmit
    input wire logic mark,
    input wire logic retransmit_request_n,
    // status
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    output logic power_down
);
    logic [PIN_W-1:0] pins_s;
    logic [DATA_W-1:0] wdata_s;
    logic wclk_s, rclk_s, sclk_s, wen_n_s, ren_n_s, sen_n_s, ld_n_s, rcs_n_s;
    logic mark_s, rt_n_s, mrs_n_s, prs_n_s, si_s, read_port_async_select_s, write_port_async_select_s, fs0_s, fs1_s;
    logic pfm_s, oe_n_s;
    logic wclk_d, rclk_d, sclk_d;
    logic wr_edge, rd_edge, sc_edge;
    logic in_mrs, in_rst;
    logic first_word_fallthrough_select_mode, rd_clocked, wr_clocked, pfm_sync, serial_prog;
    logic [PTR_W-1:0] wptr, rptr, mark_ptr, count;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [OFF_W-1:0] empty_off, full_off;
    logic wsel, rsel, rcs_q, out_valid;
    logic [FALL_W-1:0] fall_cnt;
    logic wr_req, rd_req, wr_mem, fetch, rd_take, retransmit, mem_empty, mem_full;

    // all pins pass two flops before use
    fcs_sync #(.W(PIN_W)) u_pin_sync (
        .clk(clk),
        .nrst(nrst),
        .pin_in({write_clk, read_clk, serial_clk, write_enable_n, read_enable_n,
                 serial_enable_n, offset_load_enable_n, read_chip_select_n, mark,
                 retransmit_request_n, master_reset_n, partial_reset_n,
                 first_word_fallthrough_select, read_port_async_select,
                 write_port_async_select, default_offset_select_0,
                 default_offset_select_1, flag_timing_select, output_enable_n}),
        .level_out(pins_s)
    );

    fcs_sync #(.W(DATA_W)) u_data_sync (
        .clk(clk),
        .nrst(nrst),
        .pin_in(write_data),
        .level_out(wdata_s)
    );

    assign {wclk_s, rclk_s, sclk_s, wen_n_s, ren_n_s, sen_n_s, ld_n_s, rcs_n_s, mark_s,
            rt_n_s, mrs_n_s, prs_n_s, si_s, read_port_async_select_s, write_port_async_select_s, fs0_s, fs1_s, pfm_s,
            oe_n_s} = pins_s;

    // edge detection of the port clocks
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wclk_d <= 1'b0;
            rclk_d <= 1'b0;
            sclk_d <= 1'b0;
        end
        else
        begin
            wclk_d <= wclk_s;
            rclk_d <= rclk_s;
            sclk_d <= sclk_s;
        end
    end

    assign wr_edge = wclk_s && !wclk_d;
    assign rd_edge = rclk_s && !rclk_d;
    assign sc_edge = sclk_s && !sclk_d;
    assign in_mrs = !mrs_n_s;
    assign in_rst = in_mrs || !prs_n_s;

    // configuration latched while master reset is held
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            first_word_fallthrough_select_mode <= 1'b0;
            rd_clocked <= 1'b1;
            wr_clocked <= 1'b1;
            pfm_sync <= 1'b0;
            serial_prog <= 1'b0;
        end
        else if (in_mrs)
        begin
            first_word_fallthrough_select_mode <= si_s && read_port_async_select_s;
            rd_clocked <= read_port_async_select_s;
            wr_clocked <= write_port_async_select_s;
            pfm_sync <= pfm_s;
            serial_prog <= ld_n_s;
        end
    end

    // request qualification
    assign wr_req = wr_edge && (!wr_clocked || !wen_n_s) && !in_rst;
    assign rd_req = rd_edge && (!rd_clocked || !ren_n_s) && !in_rst;
    assign count = wptr - rptr;
    assign mem_empty = (count == PTR_RESET);
    assign mem_full = (count == DEPTH);
    assign wr_mem = wr_req && ld_n_s && !mem_full;
    assign rd_take = rd_req && ld_n_s;
    assign retransmit = rd_edge && !rt_n_s && !in_rst;
    always_comb
    begin
        if (first_word_fallthrough_select_mode)
            fetch = !mem_empty && ((out_valid && rd_take) ||
                    (!out_valid && rd_edge && !in_rst && fall_cnt == FALL_LAST));
        else
            fetch = rd_take && !mem_empty;
    end

    // data storage
    always_ff @(posedge clk)
    begin
        if (wr_mem)
            mem[wptr[ADDR_W-1:0]] <= wdata_s;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wptr <= PTR_RESET;
        else if (in_rst)
            wptr <= PTR_RESET;
        else if (wr_mem)
            wptr <= wptr + 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rptr <= PTR_RESET;
        else if (in_rst)
            rptr <= PTR_RESET;
        else if (retransmit)
            rptr <= mark_ptr;
        else if (fetch)
            rptr <= rptr + 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mark_ptr <= PTR_RESET;
        else if (in_rst)
            mark_ptr <= PTR_RESET;
        else if (rd_edge && mark_s)
            mark_ptr <= rptr;
    end

    // fall-through word tracking
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            out_valid <= 1'b0;
            fall_cnt <= '0;
        end
        else if (in_rst || retransmit || !first_word_fallthrough_select_mode)
        begin
            out_valid <= 1'b0;
            fall_cnt <= '0;
        end
        else if (fetch)
        begin
            out_valid <= 1'b1;
            fall_cnt <= '0;
        end
        else if (out_valid && rd_take)
            out_valid <= 1'b0;
        else if (!out_valid && !mem_empty && rd_edge)
            fall_cnt <= fall_cnt + 1'b1;
        else if (mem_empty)
            fall_cnt <= '0;
    end

    // output register: words or offset readback
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            read_data <= QOUT_RESET;
        else if (in_rst)
            read_data <= QOUT_RESET;
        else if (fetch)
            read_data <= mem[rptr[ADDR_W-1:0]];
        else if (rd_req && !ld_n_s && rd_clocked)
            read_data <= {{(DATA_W-OFF_W){1'b0}}, rsel ? full_off : empty_off};
    end

    // offset registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            empty_off <= DEFAULT_OFFSET[0];
            full_off <= DEFAULT_OFFSET[0];
        end
        else if (in_mrs)
        begin
            empty_off <= DEFAULT_OFFSET[{ld_n_s, fs1_s, fs0_s}];
            full_off <= DEFAULT_OFFSET[{ld_n_s, fs1_s, fs0_s}];
        end
        else if (!in_rst && serial_prog && sc_edge && !sen_n_s && !ld_n_s)
            {full_off, empty_off} <= {full_off[OFF_W-2:0], empty_off, si_s};
        else if (!serial_prog && wr_req && !ld_n_s)
        begin
            if (wsel)
                full_off <= wdata_s[OFF_W-1:0];
            else
                empty_off <= wdata_s[OFF_W-1:0];
        end
    end

    // offset access sequencers restart whenever load is released
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wsel <= 1'b0;
            rsel <= 1'b0;
        end
        else if (in_rst || ld_n_s)
        begin
            wsel <= 1'b0;
            rsel <= 1'b0;
        end
        else
        begin
            if (wr_req && !serial_prog)
                wsel <= !wsel;
            if (rd_req && rd_clocked)
                rsel <= !rsel;
        end
    end

    // chip select sampled on the read clock
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rcs_q <= 1'b1;
        else if (rd_edge)
            rcs_q <= rcs_n_s;
    end

    assign read_data_oe = !oe_n_s && (in_rst || !rcs_q);

    // status flags
    always_comb
    begin
        if (first_word_fallthrough_select_mode)
        begin
            empty_flag_n = !out_valid;
            full_flag_n = mem_full;
        end
        else
        begin
            empty_flag_n = !mem_empty;
            full_flag_n = !mem_full;
        end
    end

    fcs_flags u_flags (
        .clk(clk),
        .nrst(nrst),
        .sync_mode(pfm_sync),
        .rd_edge(rd_edge),
        .wr_edge(wr_edge),
        .count(count),
        .empty_off(empty_off),
        .full_off(full_off),
        .almost_empty_flag_n(almost_empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n)
    );

    assign power_down = !(in_rst || wr_edge || rd_edge || sc_edge || !wen_n_s ||
                          !ren_n_s || !sen_n_s || !ld_n_s || mark_s || !rt_n_s);

    chk_rst_ptrs: assert property (@(posedge clk) disable iff (!nrst)
        in_rst |=> (wptr == PTR_RESET && rptr == PTR_RESET
                    && read_data == QOUT_RESET))
        else $error("pointers not cleared by reset");
    chk_oe_reset: assert property (@(posedge clk) disable iff (!nrst)
        in_rst |-> (read_data_oe == !oe_n_s))
        else $error("chip select affected outputs during reset");
    chk_full_block: assert property (@(posedge clk) disable iff (!nrst)
        (wr_req && mem_full && !in_rst) |=> (wptr == $past(wptr)))
        else $error("write accepted while full");
    chk_std_read: assert property (@(posedge clk) disable iff (!nrst)
        (!first_word_fallthrough_select_mode && rd_take && !mem_empty && !retransmit)
        |=> (rptr == $past(rptr) + 1'b1))
        else $error("standard read did not advance");
    chk_retransmit_ptr: assert property (@(posedge clk) disable iff (!nrst)
        retransmit |=> (rptr == $past(mark_ptr)))
        else $error("retransmit did not restore marked pointer");
    chk_write_store: assert property (@(posedge clk) disable iff (!nrst)
        (wr_edge && wr_clocked && !wen_n_s && !in_rst && ld_n_s && !mem_full)
        |=> (wptr == $past(wptr) + 1'b1))
        else $error("clocked write not stored");
    chk_wake_now: assert property (@(posedge clk) disable iff (!nrst)
        (wr_edge || rd_edge || in_rst) |-> !power_down)
        else $error("power-down held during an operation");
    chk_empty_pin: assert property (@(posedge clk) disable iff (!nrst)
        !first_word_fallthrough_select_mode |-> (empty_flag_n == (count != PTR_RESET)))
        else $error("empty flag wrong in standard mode");
    chk_full_pin: assert property (@(posedge clk) disable iff (!nrst)
        first_word_fallthrough_select_mode |-> (full_flag_n == (count == DEPTH)))
        else $error("input ready wrong in fall-through mode");
endmodule
`default_nettype wire

// [hdl/fcs_pkg.sv]
// constants and configuration tables of the dual-port fifo
package fcs_pkg;
    localparam int DATA_W = 36;
    localparam int ADDR_W = 19;
    localparam int PTR_W = ADDR_W + 1;
    localparam int OFF_W = ADDR_W;
    localparam logic [PTR_W-1:0] DEPTH = 20'h8_0000;
    localparam logic [PTR_W-1:0] PTR_RESET = 20'h0_0000;
    localparam logic [DATA_W-1:0] QOUT_RESET = 36'h0_0000_0000;
    localparam int PIN_W = 19;
    localparam int FALL_W = 2;
    localparam logic [FALL_W-1:0] FALL_LAST = 2'h2;
    // default offsets chosen by {load, select_1, select_0} at master reset
    localparam logic [OFF_W-1:0] DEFAULT_OFFSET [0:7] = '{
        19'h0_0007, 19'h0_000f, 19'h0_001f, 19'h0_003f,
        19'h0_007f, 19'h0_00ff, 19'h0_01ff, 19'h0_03ff
    };
endpackage

// [hdl/fcs_sync.sv]
// two-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
`default_nettype none
module fcs_sync
    import fcs_pkg::*;
#(
    parameter int W = 1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // levels
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1 <= '0;
            level_out <= '0;
        end
        else
        begin
            stage1 <= pin_in;
            level_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// [hdl/fcs_flags.sv]
// almost-empty and almost-full threshold flags
`timescale 1ns/100ps
`default_nettype none
module fcs_flags
    import fcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // mode and update events
    input wire logic sync_mode,
    input wire logic rd_edge,
    input wire logic wr_edge,
    // levels compared
    input wire logic [PTR_W-1:0] count,
    input wire logic [OFF_W-1:0] empty_off,
    input wire logic [OFF_W-1:0] full_off,
    // flags, active low
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n
);
    logic [PTR_W-1:0] free_cnt;
    logic next_ae_n;
    logic next_af_n;

    assign free_cnt = DEPTH - count;
    assign next_ae_n = !(count < {1'b0, empty_off});
    assign next_af_n = !(free_cnt <= {1'b0, full_off});

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            almost_empty_flag_n <= 1'b0;
        else if (!sync_mode || rd_edge)
            almost_empty_flag_n <= next_ae_n;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            almost_full_flag_n <= 1'b1;
        else if (!sync_mode || wr_edge)
            almost_full_flag_n <= next_af_n;
    end

    chk_ae_sync_hold: assert property (@(posedge clk) disable iff (!nrst)
        (sync_mode && !rd_edge) |=> $stable(almost_empty_flag_n))
        else $error("almost-empty changed without read clock edge");
    chk_af_sync_hold: assert property (@(posedge clk) disable iff (!nrst)
        (sync_mode && !wr_edge) |=> $stable(almost_full_flag_n))
        else $error("almost-full changed without write clock edge");
endmodule
`default_nettype wire

// [tb/fcs_far_end.sv]
// far-end writer and reader that drive the fifo port clocks
`timescale 1ns/100ps
`default_nettype none
module fcs_far_end
    import fcs_pkg::*;
(
    // system clock
    input wire logic clk,
    // write side
    output var logic write_clk,
    output var logic write_enable_n,
    output var logic [DATA_W-1:0] write_data,
    // read side
    output var logic read_clk,
    output var logic read_enable_n
);
    initial
    begin
        write_clk = 1'b0;
        write_enable_n = 1'b1;
        write_data = '0;
        read_clk = 1'b0;
        read_enable_n = 1'b1;
    end
    // one port clock pulse, each phase four system cycles
    task automatic pulse(input logic wr);
        repeat (4) @(negedge clk);
        if (wr)
            write_clk = 1'b1;
        else
            read_clk = 1'b1;
        repeat (4) @(negedge clk);
        if (wr)
            write_clk = 1'b0;
        else
            read_clk = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // clocked write, enable held across the whole pulse
    task automatic push(input logic [DATA_W-1:0] word);
        @(negedge clk);
        write_data = word;
        write_enable_n = 1'b0;
        pulse(1'b1);
        write_enable_n = 1'b1;
        write_data = ~word;
    endtask
    // strobed write, enable left inactive since strobed mode ignores it
    task automatic strobe(input logic [DATA_W-1:0] word);
        @(negedge clk);
        write_data = word;
        pulse(1'b1);
        write_data = ~word;
    endtask
    // clocked read edge, enable given by caller
    task automatic pull(input logic en_n);
        @(negedge clk);
        read_enable_n = en_n;
        pulse(1'b0);
        read_enable_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// [tb/fcs_fifo_tb.sv]
// self-checking bench of the dual-port fifo
`timescale 1ns/100ps
`default_nettype none
module fcs_fifo_tb
    import fcs_pkg::*;
;
    logic clk, nrst, write_clk, write_enable_n, read_clk, read_enable_n;
    logic [DATA_W-1:0] write_data, read_data;
    logic read_chip_select_n, output_enable_n, read_data_oe;
    logic master_reset_n, partial_reset_n, read_port_async_select, write_port_async_select;
    logic default_offset_select_0, default_offset_select_1, flag_timing_select;
    logic first_word_fallthrough_select, offset_load_enable_n, serial_clk, serial_enable_n;
    logic mark, retransmit_request_n, empty_flag_n, full_flag_n;
    logic almost_empty_flag_n, almost_full_flag_n, power_down;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [38:0] row;
    // rows: {read, word, empty_flag_n, almost_empty_flag_n}, offset 7
    localparam logic [38:0] ROWS [0:13] = '{
        {1'b0, 36'h8_0000_0001, 1'b1, 1'b0}, {1'b0, 36'h8_0000_0002, 1'b1, 1'b0},
        {1'b0, 36'h8_0000_0003, 1'b1, 1'b0}, {1'b0, 36'h8_0000_0004, 1'b1, 1'b0},
        {1'b0, 36'h8_0000_0005, 1'b1, 1'b0}, {1'b0, 36'h8_0000_0006, 1'b1, 1'b0},
        {1'b0, 36'h8_0000_0007, 1'b1, 1'b1}, {1'b1, 36'h8_0000_0001, 1'b1, 1'b0},
        {1'b1, 36'h8_0000_0002, 1'b1, 1'b0}, {1'b1, 36'h8_0000_0003, 1'b1, 1'b0},
        {1'b1, 36'h8_0000_0004, 1'b1, 1'b0}, {1'b1, 36'h8_0000_0005, 1'b1, 1'b0},
        {1'b1, 36'h8_0000_0006, 1'b1, 1'b0}, {1'b1, 36'h8_0000_0007, 1'b0, 1'b0}
    };

    fcs_fifo i_fcs_fifo (.clk(clk), .nrst(nrst), .write_clk(write_clk),
        .write_enable_n(write_enable_n), .write_data(write_data), .read_clk(read_clk),
        .read_enable_n(read_enable_n), .read_chip_select_n(read_chip_select_n),
        .output_enable_n(output_enable_n), .read_data(read_data), .read_data_oe(read_data_oe),
        .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
        .read_port_async_select(read_port_async_select),
        .write_port_async_select(write_port_async_select),
        .default_offset_select_0(default_offset_select_0),
        .default_offset_select_1(default_offset_select_1),
        .flag_timing_select(flag_timing_select),
        .first_word_fallthrough_select(first_word_fallthrough_select),
        .offset_load_enable_n(offset_load_enable_n), .serial_clk(serial_clk),
        .serial_enable_n(serial_enable_n), .mark(mark),
        .retransmit_request_n(retransmit_request_n), .empty_flag_n(empty_flag_n),
        .full_flag_n(full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n), .power_down(power_down));

    fcs_far_end i_fcs_far_end (.clk(clk), .write_clk(write_clk),
        .write_enable_n(write_enable_n), .write_data(write_data), .read_clk(read_clk),
        .read_enable_n(read_enable_n));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // master reset pulse, configuration pins already set
    task automatic mreset();
        @(negedge clk);
        master_reset_n = 1'b0;
        repeat (6) @(negedge clk);
        master_reset_n = 1'b1;
        repeat (5) @(negedge clk);
        offset_load_enable_n = 1'b1;
        repeat (5) @(negedge clk);
    endtask

    // serial offset load, full offset msb first, load and enable already low
    task automatic shift_offsets(input logic [37:0] bits);
        for (int i = 37; i >= 0; i--)
        begin
            first_word_fallthrough_select = bits[i];
            repeat (4) @(negedge clk);
            serial_clk = 1'b1;
            repeat (4) @(negedge clk);
            serial_clk = 1'b0;
        end
        repeat (4) @(negedge clk);
    endtask

    initial
    begin
        nrst = 1'b0;
        master_reset_n = 1'b0;
        partial_reset_n = 1'b1;
        read_port_async_select = 1'b1;
        write_port_async_select = 1'b1;
        default_offset_select_0 = 1'b0;
        default_offset_select_1 = 1'b0;
        flag_timing_select = 1'b0;
        first_word_fallthrough_select = 1'b0;
        offset_load_enable_n = 1'b0;
        serial_clk = 1'b0;
        serial_enable_n = 1'b1;
        mark = 1'b0;
        retransmit_request_n = 1'b1;
        output_enable_n = 1'b0;
        read_chip_select_n = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        mreset();
        cmp_bit(power_down, 1'b1);
        cmp_word(read_data, 36'h0_0000_0000);
        offset_load_enable_n = 1'b0;
        i_fcs_far_end.pull(1'b0);
        cmp_word(read_data, 36'h0_0000_0007);
        i_fcs_far_end.pull(1'b0);
        cmp_word(read_data, 36'h0_0000_0007);
        offset_load_enable_n = 1'b1;
        for (int i = 0; i < 14; i++)
        begin
            row = ROWS[i];
            if (row[38])
            begin
                i_fcs_far_end.pull(1'b0);
                cmp_word(read_data, row[37:2]);
            end
            else
                i_fcs_far_end.push(row[37:2]);
            cmp_bit(empty_flag_n, row[1]);
            cmp_bit(almost_empty_flag_n, row[0]);
            cmp_bit(full_flag_n, 1'b1);
            cmp_bit(almost_full_flag_n, 1'b1);
        end
        i_fcs_far_end.pull(1'b0);
        cmp_word(read_data, 36'h8_0000_0007);
        cmp_bit(empty_flag_n, 1'b0);
        output_enable_n = 1'b1;
        repeat (4) @(negedge clk);
        cmp_bit(read_data_oe, 1'b0);
        output_enable_n = 1'b0;
        read_chip_select_n = 1'b1;
        i_fcs_far_end.pull(1'b1);
        cmp_bit(read_data_oe, 1'b0);
        i_fcs_far_end.push(36'h8_0000_00a1);
        partial_reset_n = 1'b0;
        repeat (6) @(negedge clk);
        cmp_bit(read_data_oe, 1'b1);
        cmp_bit(empty_flag_n, 1'b0);
        cmp_word(read_data, 36'h0_0000_0000);
        partial_reset_n = 1'b1;
        read_chip_select_n = 1'b0;
        repeat (5) @(negedge clk);
        i_fcs_far_end.push(36'h8_0000_00c1);
        i_fcs_far_end.push(36'h8_0000_00c2);
        mark = 1'b1;
        i_fcs_far_end.pull(1'b1);
        mark = 1'b0;
        i_fcs_far_end.pull(1'b0);
        cmp_word(read_data, 36'h8_0000_00c1);
        i_fcs_far_end.pull(1'b0);
        cmp_word(read_data, 36'h8_0000_00c2);
        retransmit_request_n = 1'b0;
        i_fcs_far_end.pull(1'b1);
        retransmit_request_n = 1'b1;
        i_fcs_far_end.pull(1'b0);
        cmp_word(read_data, 36'h8_0000_00c1);
        offset_load_enable_n = 1'b0;
        i_fcs_far_end.pull(1'b0);
        cmp_word(read_data, 36'h0_0000_0007);
        offset_load_enable_n = 1'b1;
        default_offset_select_0 = 1'b1;
        default_offset_select_1 = 1'b1;
        flag_timing_select = 1'b1;
        first_word_fallthrough_select = 1'b1;
        mreset();
        first_word_fallthrough_select = 1'b0;
        cmp_bit(empty_flag_n, 1'b1);
        cmp_bit(full_flag_n, 1'b0);
        i_fcs_far_end.push(36'h8_0000_00e1);
        i_fcs_far_end.pull(1'b1);
        i_fcs_far_end.pull(1'b1);
        cmp_bit(empty_flag_n, 1'b1);
        i_fcs_far_end.pull(1'b1);
        cmp_word(read_data, 36'h8_0000_00e1);
        cmp_bit(empty_flag_n, 1'b0);
        read_port_async_select = 1'b0;
        write_port_async_select = 1'b0;
        flag_timing_select = 1'b0;
        first_word_fallthrough_select = 1'b1;
        offset_load_enable_n = 1'b0;
        mreset();
        cmp_bit(empty_flag_n, 1'b0);
        offset_load_enable_n = 1'b0;
        i_fcs_far_end.strobe(36'h0_0000_0002);
        i_fcs_far_end.strobe(36'h0_0007_ffff);
        offset_load_enable_n = 1'b1;
        cmp_bit(almost_full_flag_n, 1'b1);
        i_fcs_far_end.strobe(36'h8_0000_00b1);
        cmp_bit(almost_full_flag_n, 1'b0);
        cmp_bit(almost_empty_flag_n, 1'b0);
        i_fcs_far_end.strobe(36'h8_0000_00b2);
        cmp_bit(almost_empty_flag_n, 1'b1);
        i_fcs_far_end.pull(1'b1);
        cmp_word(read_data, 36'h8_0000_00b1);
        read_port_async_select = 1'b1;
        write_port_async_select = 1'b1;
        flag_timing_select = 1'b1;
        first_word_fallthrough_select = 1'b0;
        mreset();
        offset_load_enable_n = 1'b0;
        serial_enable_n = 1'b0;
        repeat (3) @(negedge clk);
        cmp_bit(power_down, 1'b0);
        shift_offsets({19'h0_0005, 19'h0_0003});
        serial_enable_n = 1'b1;
        i_fcs_far_end.pull(1'b0);
        cmp_word(read_data, 36'h0_0000_0003);
        i_fcs_far_end.pull(1'b0);
        cmp_word(read_data, 36'h0_0000_0005);
        offset_load_enable_n = 1'b1;
        repeat (3) i_fcs_far_end.push(36'h8_0000_00d1);
        cmp_bit(almost_empty_flag_n, 1'b0);
        i_fcs_far_end.pull(1'b1);
        cmp_bit(almost_empty_flag_n, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
